// [npe_ecc_regs.sv]
`timescale 1ns/1ps
module npe_ecc_regs
  import npe_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire npe_ham_res_t ham_res,
  input wire npe_rs_res_t rs_res,
  input wire npe_red_t red_in,
  input wire logic cmd_detect,
  input wire logic soft_reset,
  input wire logic cor_done,
  output logic cor_start,
  output logic [2:0] cor_sub,
  output logic [2:0] correction_type,
  output logic irq
);
  logic [2:0] type_reg;
  logic [2:0] sub_reg;
  npe_state_t state_reg;
  logic start_req;
  logic cor_start_reg;
  logic [23:0] par_reg [NPE_SECTORS];
  logic [NPE_SECTORS-1:0] multi_reg;
  logic [NPE_SECTORS-1:0] single_reg;
  logic rs_multi_reg;
  logic [2:0] rs_count_reg;
  logic [79:0] stage_reg;
  logic [79:0] red_full;
  logic [7:0] cw_reg [NPE_CW_BYTES];
  logic done_reg;
  logic mask_reg;
  logic irq_reg;
  logic [31:0] hrdata_reg;
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic addr_ok;
  logic rd_istat;
  logic ham_mode;
  logic ham_take;
  logic ctrl_wr;
  logic [31:0] rd_val;

  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_istat = addr_ok && !hwrite && (haddr[11:0] == NPE_OFS_ISTAT);
  assign ctrl_wr = wr_pend_reg && (wr_addr_reg == NPE_OFS_CTRL);
  assign ham_mode = !type_reg[NPE_TYPE_RS_BIT];
  assign ham_take = ham_res.valid && ham_mode &&
                    ((type_reg == NPE_TYPE_S256) ||
                     ((type_reg == NPE_TYPE_S512) && (ham_res.sector < 4'(NPE_SECT_512))) ||
                     ((type_reg == NPE_TYPE_PAGE) && (ham_res.sector == 4'h0)));
  assign start_req = ctrl_wr && hwdata[NPE_CTRL_START_BIT];

  // Bus write phase bookkeeping
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[11:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      type_reg <= NPE_TYPE_PAGE;
      sub_reg <= 3'h0;
    end else if (ctrl_wr) begin
      type_reg <= hwdata[NPE_CTRL_TYPE_LSB +: 3];
      sub_reg <= hwdata[NPE_CTRL_SUB_LSB +: 3];
    end
  end

  // One correction run at a time, for one sub-page
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= NPE_IDLE;
      cor_start_reg <= 1'b0;
      cor_sub <= 3'h0;
    end else begin
      cor_start_reg <= 1'b0;
      unique case (state_reg)
        NPE_IDLE: begin
          if (start_req && type_reg[NPE_TYPE_RS_BIT]) begin
            state_reg <= NPE_RUN;
            cor_start_reg <= 1'b1;
            cor_sub <= hwdata[NPE_CTRL_SUB_LSB +: 3];
          end
        end
        NPE_RUN: begin
          if (cor_done || soft_reset) begin
            state_reg <= NPE_IDLE;
          end
        end
      endcase
    end
  end
  assign cor_start = cor_start_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      correction_type <= NPE_TYPE_PAGE;
    end else begin
      correction_type <= type_reg;
    end
  end

  // Per-sector parity and error flags
  genvar n;
  generate
    for (n = 0; n < NPE_SECTORS; n++) begin : g_sec
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          par_reg[n] <= NPE_RST_VAL[23:0];
          multi_reg[n] <= 1'b0;
          single_reg[n] <= 1'b0;
        end else if (ham_take && (ham_res.sector == 4'(n))) begin
          if (ham_res.is_read) begin
            multi_reg[n] <= ham_res.multi;
            single_reg[n] <= ham_res.single && !ham_res.multi;
            if (type_reg == NPE_TYPE_PAGE) begin
              par_reg[n] <= par_reg[n];
            end else if (ham_res.single && !ham_res.multi) begin
              if (type_reg == NPE_TYPE_S256) begin
                par_reg[n][11:0] <= {1'b0, ham_res.word[7:0], ham_res.bit_ofs};
              end else begin
                par_reg[n][11:0] <= {ham_res.word[8:0], ham_res.bit_ofs};
              end
            end else begin
              par_reg[n][11:0] <= 12'h000;
            end
          end else if (type_reg == NPE_TYPE_S256) begin
            par_reg[n] <= {1'b0, ham_res.parity[10:0], 12'h000};
          end else if (type_reg == NPE_TYPE_S512) begin
            par_reg[n] <= {ham_res.parity[11:0], 12'h000};
          end else begin
            par_reg[n] <= {8'h00, ham_res.parity};
          end
        end
      end
    end
  endgenerate

  // Page mode keeps the error location in the first parity register
  logic [14:0] page_loc_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_loc_reg <= 15'h0000;
    end else if (ham_take && ham_res.is_read && (type_reg == NPE_TYPE_PAGE)) begin
      page_loc_reg <= ham_res.single ? {ham_res.word, ham_res.bit_ofs} : 15'h0000;
    end
  end

  // Reed-Solomon status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_multi_reg <= 1'b0;
      rs_count_reg <= 3'h0;
    end else if (rs_res.valid && type_reg[NPE_TYPE_RS_BIT]) begin
      rs_multi_reg <= rs_res.multi;
      rs_count_reg <= rs_res.multi ? 3'h0 : rs_res.count;
    end else if (cmd_detect || soft_reset) begin
      rs_multi_reg <= 1'b0;
    end
  end

  // Redundancy words packed into bytes
  always_comb begin
    red_full = stage_reg;
    red_full[red_in.idx * NPE_RED_W +: NPE_RED_W] = red_in.word;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= 80'h0;
    end else if (red_in.valid && type_reg[NPE_TYPE_RS_BIT]) begin
      stage_reg <= red_full;
    end
  end

  genvar k;
  generate
    for (k = 0; k < NPE_CW_BYTES; k++) begin : g_cw
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cw_reg[k] <= 8'h00;
        end else if (red_in.valid && type_reg[NPE_TYPE_RS_BIT] &&
                     (red_in.idx == 3'(NPE_RED_WORDS - 1)) &&
                     (red_in.sub == 3'(k / NPE_BYTES_PER_SUB))) begin
          cw_reg[k] <= red_full[8 * (k % NPE_BYTES_PER_SUB) +: 8];
        end
      end
    end
  endgenerate

  // Interrupt status, mask and output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else if (cor_done) begin
      done_reg <= 1'b1;
    end else if (rd_istat ||
                 (wr_pend_reg && (wr_addr_reg == NPE_OFS_ICLR) &&
                  hwdata[NPE_INT_DONE_BIT])) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= 1'b0;
    end else if (wr_pend_reg && (wr_addr_reg == NPE_OFS_IMASK)) begin
      mask_reg <= hwdata[NPE_INT_DONE_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= done_reg && mask_reg;
    end
  end
  assign irq = irq_reg;

  // Read mux
  function automatic logic [31:0] sec_status(input int base);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 8; i++) begin
      v[4 * i +: 3] = {multi_reg[base + i], single_reg[base + i],
                       single_reg[base + i]};
    end
    return v;
  endfunction

  function automatic logic [31:0] pr_read(input int idx);
    logic [31:0] v;
    v = 32'h0;
    if (type_reg == NPE_TYPE_PAGE) begin
      if (idx == 0) begin
        v = {17'h0, page_loc_reg};
      end else if (idx == 1) begin
        v = {16'h0, par_reg[0][15:0]};
      end
    end else if (ham_mode && !((type_reg == NPE_TYPE_S512) && (idx >= NPE_SECT_512))) begin
      v = {8'h00, par_reg[idx]};
    end
    return v;
  endfunction

  always_comb begin
    logic [11:0] a;
    int cw_i;
    int pr_i;
    a = haddr[11:0];
    cw_i = (int'(a) - int'(NPE_OFS_CW0)) / 4;
    pr_i = (int'(a) - int'(NPE_OFS_PR2)) / 4 + 2;
    rd_val = 32'h0;
    if (a[1:0] == 2'b00) begin
      if (a == NPE_OFS_CTRL) begin
        rd_val = {21'h0, sub_reg, 5'h0, type_reg};
      end else if (a == NPE_OFS_SR1) begin
        if (type_reg[NPE_TYPE_RS_BIT]) begin
          rd_val = {28'h0, rs_multi_reg, rs_count_reg};
        end else begin
          rd_val = sec_status(0);
        end
      end else if (a == NPE_OFS_SR2) begin
        rd_val = ham_mode ? sec_status(8) : 32'h0;
      end else if (a == NPE_OFS_PR0) begin
        rd_val = pr_read(0);
      end else if (a == NPE_OFS_PR1) begin
        rd_val = pr_read(1);
      end else if ((a >= NPE_OFS_PR2) && (a <= NPE_OFS_PR15)) begin
        rd_val = pr_read(pr_i);
      end else if ((a >= NPE_OFS_CW0) && (a <= NPE_OFS_CW79)) begin
        rd_val = {24'h0, cw_reg[cw_i]};
      end else if (a == NPE_OFS_IMASK) begin
        rd_val = {31'h0, mask_reg};
      end else if (a == NPE_OFS_ISTAT) begin
        rd_val = {31'h0, done_reg};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_reg <= NPE_RST_VAL;
    end else if (addr_ok && !hwrite) begin
      hrdata_reg <= rd_val;
    end
  end
  assign hrdata = hrdata_reg;

  // Checks
  a_mode_select: assert property (@(posedge clk) disable iff (!arst_n)
    (rs_res.valid && !type_reg[NPE_TYPE_RS_BIT] && !cmd_detect && !soft_reset)
      |=> $stable(rs_multi_reg) && $stable(rs_count_reg))
    else $error("RS status moved in Hamming mode");
  a_page_only: assert property (@(posedge clk) disable iff (!arst_n)
    (ham_res.valid && (type_reg == NPE_TYPE_PAGE) && (ham_res.sector != 4'h0))
      |=> $stable(multi_reg) && $stable(single_reg))
    else $error("Page mode touched another sector");
  a_multi_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (ham_take && ham_res.is_read && ham_res.multi) |=> multi_reg[$past(ham_res.sector)])
    else $error("Sector multi error not set");
  a_single_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (ham_take && ham_res.is_read && !ham_res.single && !ham_res.multi)
      |=> !single_reg[$past(ham_res.sector)] && !multi_reg[$past(ham_res.sector)])
    else $error("Sector flag set with no error");
  a_run_once: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == NPE_RUN) |=> !cor_start_reg)
    else $error("Second run started");
  a_rs_multi: assert property (@(posedge clk) disable iff (!arst_n)
    (rs_res.valid && type_reg[NPE_TYPE_RS_BIT] && rs_res.multi) |=> rs_multi_reg ##1 1'b1)
    else $error("RS multi error not set");
  a_rs_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_detect && !rs_res.valid) |=> !rs_multi_reg)
    else $error("RS multi error not cleared");
  a_rs_count: assert property (@(posedge clk) disable iff (!arst_n)
    rs_multi_reg |-> (rs_count_reg == 3'h0))
    else $error("Count shown with multi error");
  a_par_256: assert property (@(posedge clk) disable iff (!arst_n)
    (ham_take && !ham_res.is_read && (type_reg == NPE_TYPE_S256))
      |=> (par_reg[$past(ham_res.sector)][22:12] == $past(ham_res.parity[10:0])) &&
          !par_reg[$past(ham_res.sector)][11])
    else $error("256 byte parity layout wrong");
  a_par_512: assert property (@(posedge clk) disable iff (!arst_n)
    (ham_take && !ham_res.is_read && (type_reg == NPE_TYPE_S512))
      |=> (par_reg[$past(ham_res.sector)] == {$past(ham_res.parity[11:0]), 12'h000}))
    else $error("512 byte parity layout wrong");
  a_word_load: assert property (@(posedge clk) disable iff (!arst_n)
    (ham_take && ham_res.is_read && ham_res.single && !ham_res.multi &&
     (type_reg == NPE_TYPE_S512))
      |=> (par_reg[$past(ham_res.sector)][11:0] ==
           {$past(ham_res.word[8:0]), $past(ham_res.bit_ofs)}))
    else $error("Error location not loaded");
  a_page_parity: assert property (@(posedge clk) disable iff (!arst_n)
    (ham_take && ham_res.is_read && (type_reg == NPE_TYPE_PAGE)) |=> $stable(par_reg[0]))
    else $error("Page parity overwritten");
  a_hi_unused: assert property (@(posedge clk) disable iff (!arst_n)
    (ham_res.valid && (type_reg == NPE_TYPE_S512) && ham_res.sector[3]) |=> $stable(multi_reg))
    else $error("Unused sector written");
  a_done_set: assert property (@(posedge clk) disable iff (!arst_n)
    cor_done |=> done_reg ##1 (irq_reg || !mask_reg || !done_reg))
    else $error("Done flag or interrupt missing");
endmodule

// [npe_pkg.sv]
// Functional notes
// - Type top bit picks Hamming or RS code
// - Type 0 page, 1 256B, 2 512B
// - Sector multi-error flag set on several errors
// - Sector single-error flag set on one error
// - RS corrects one sub-page per run
// - RS multi-error bit set above four errors
// - Read/write command or soft reset clears it
// - RS error count 0 to 4, coded
// - 256B parity, zero bit, word, bit fields
// - 512B parity, word, bit fields
// - 512B mode: parity registers above PR7 unused
// - Word and bit loaded on single error
// - Eight 10-bit words form ten bytes
// - Redundancy byte in codeword low byte
// - Correction done flag, write-one clears it
package npe_pkg;
  localparam int NPE_SECTORS = 16;
  localparam int NPE_SECT_512 = 8;
  localparam int NPE_CW_BYTES = 80;
  localparam int NPE_RED_WORDS = 8;
  localparam int NPE_BYTES_PER_SUB = 10;
  localparam int NPE_RED_W = 10;
  localparam logic [11:0] NPE_OFS_CTRL = 12'h000;
  localparam logic [11:0] NPE_OFS_SR1 = 12'h008;
  localparam logic [11:0] NPE_OFS_PR0 = 12'h00c;
  localparam logic [11:0] NPE_OFS_PR1 = 12'h010;
  localparam logic [11:0] NPE_OFS_SR2 = 12'h014;
  localparam logic [11:0] NPE_OFS_PR2 = 12'h018;
  localparam logic [11:0] NPE_OFS_PR15 = 12'h04c;
  localparam logic [11:0] NPE_OFS_CW0 = 12'h050;
  localparam logic [11:0] NPE_OFS_CW79 = 12'h18c;
  localparam logic [11:0] NPE_OFS_IMASK = 12'h1b8;
  localparam logic [11:0] NPE_OFS_ISTAT = 12'h1bc;
  localparam logic [11:0] NPE_OFS_ICLR = 12'h1c0;
  localparam int NPE_CTRL_TYPE_LSB = 0;
  localparam int NPE_CTRL_START_BIT = 4;
  localparam int NPE_CTRL_SUB_LSB = 8;
  localparam logic [2:0] NPE_TYPE_PAGE = 3'h0;
  localparam logic [2:0] NPE_TYPE_S256 = 3'h1;
  localparam logic [2:0] NPE_TYPE_S512 = 3'h2;
  localparam int NPE_TYPE_RS_BIT = 2;
  localparam int NPE_PAR_LSB = 12;
  localparam int NPE_WORD_LSB = 3;
  localparam int NPE_RS_MULTI_BIT = 3;
  localparam int NPE_INT_DONE_BIT = 0;
  localparam logic [31:0] NPE_RST_VAL = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic [3:0] sector;
    logic single;
    logic multi;
    logic [15:0] parity;
    logic [11:0] word;
    logic [2:0] bit_ofs;
  } npe_ham_res_t;

  typedef struct packed {
    logic valid;
    logic multi;
    logic [2:0] count;
  } npe_rs_res_t;

  typedef struct packed {
    logic valid;
    logic [2:0] sub;
    logic [2:0] idx;
    logic [9:0] word;
  } npe_red_t;

  typedef enum logic [1:0] {
    NPE_IDLE = 2'b01,
    NPE_RUN = 2'b10
  } npe_state_t;
endpackage

// [nand_page_ecc_status_parity_tb.sv]
`timescale 1ns/1ps
module nand_page_ecc_status_parity_tb;
  import npe_pkg::*;
  logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, cor_sub, correction_type, sub_seen;
  npe_ham_res_t ham_res;
  npe_rs_res_t rs_res;
  npe_red_t red_in;
  logic cmd_detect, soft_reset, cor_done, cor_start, irq;
  logic [79:0] red_bits;
  int failures, checks, starts;

  npe_ecc_regs npe_ecc_regs_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ham_res(ham_res),
    .rs_res(rs_res), .red_in(red_in), .cmd_detect(cmd_detect), .soft_reset(soft_reset),
    .cor_done(cor_done), .cor_start(cor_start), .cor_sub(cor_sub),
    .correction_type(correction_type), .irq(irq));

  assign hready = hreadyout;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    if (wr) hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic ham(input logic r, input logic [3:0] s, input logic sg, input logic m,
                     input logic [15:0] p, input logic [11:0] w, input logic [2:0] b);
    @(posedge clk);
    ham_res <= '{1'b1, r, s, sg, m, p, w, b};
    @(posedge clk);
    ham_res <= '0;
  endtask

  task automatic rs(input logic m, input logic [2:0] c);
    @(posedge clk);
    rs_res <= '{1'b1, m, c};
    @(posedge clk);
    rs_res <= '0;
  endtask

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) cmd_detect <= 1'b1;
    else if (which == 1) soft_reset <= 1'b1;
    else cor_done <= 1'b1;
    @(posedge clk);
    cmd_detect <= 1'b0;
    soft_reset <= 1'b0;
    cor_done <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (cor_start === 1'b1) begin
      starts++;
      sub_seen = cor_sub;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    arst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = '0; ham_res = '0; rs_res = '0; red_in = '0;
    cmd_detect = 1'b0; soft_reset = 1'b0; cor_done = 1'b0;
    failures = 0; checks = 0; starts = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk({29'h0, correction_type}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    rchk(NPE_OFS_PR2, NPE_RST_VAL);
    rchk(NPE_OFS_CW79, NPE_RST_VAL);
    rchk(NPE_OFS_SR2, NPE_RST_VAL);
    bus(1'b1, 12'h1f0, 32'hffff_ffff);
    rchk(12'h1f0, 32'h0);
    // Page-wide mode: only sector 0 counts
    bus(1'b1, NPE_OFS_CTRL, {29'h0, NPE_TYPE_PAGE});
    repeat (2) @(posedge clk);
    chk({29'h0, correction_type}, {29'h0, NPE_TYPE_PAGE});
    ham(1'b0, 4'h0, 1'b0, 1'b0, 16'hbeef, 12'h0, 3'h0);
    ham(1'b1, 4'h0, 1'b1, 1'b0, 16'h0, 12'h123, 3'h6);
    ham(1'b1, 4'h1, 1'b1, 1'b0, 16'h0, 12'h0aa, 3'h1);
    rchk(NPE_OFS_PR1, 32'h0000_beef);
    rchk(NPE_OFS_PR0, 32'h0000_091e);
    rchk(NPE_OFS_SR1, 32'h0000_0003);
    // 256-byte sectors
    bus(1'b1, NPE_OFS_CTRL, {29'h0, NPE_TYPE_S256});
    ham(1'b0, 4'h2, 1'b0, 1'b0, 16'hffff, 12'h0, 3'h0);
    rchk(NPE_OFS_PR2, 32'h007f_f000);
    ham(1'b1, 4'h2, 1'b1, 1'b0, 16'h0, 12'h0a5, 3'h3);
    ham(1'b1, 4'h9, 1'b0, 1'b1, 16'h0, 12'h011, 3'h2);
    rchk(NPE_OFS_PR2, 32'h007f_f52b);
    bus(1'b0, NPE_OFS_SR1, 32'h0);
    chk(rd & 32'h0000_0ff0, 32'h0000_0300);
    rchk(NPE_OFS_SR2, 32'h0000_0040);
    // 512-byte sectors, sector 8 has no register
    bus(1'b1, NPE_OFS_CTRL, {29'h0, NPE_TYPE_S512});
    ham(1'b0, 4'h3, 1'b0, 1'b0, 16'hffff, 12'h0, 3'h0);
    ham(1'b1, 4'h3, 1'b1, 1'b0, 16'h0, 12'h1ab, 3'h5);
    ham(1'b0, 4'h8, 1'b0, 1'b0, 16'h0fff, 12'h0, 3'h0);
    rchk(NPE_OFS_PR2 + 12'h004, 32'h00ff_fd5d);
    rchk(NPE_OFS_PR2 + 12'h018, 32'h0);
    // Reed-Solomon status
    bus(1'b1, NPE_OFS_CTRL, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk({29'h0, correction_type}, 32'h4);
    for (int c = 0; c <= 4; c++) begin
      rs(1'b0, 3'(c));
      rchk(NPE_OFS_SR1, 32'(c));
    end
    ham(1'b0, 4'h4, 1'b0, 1'b0, 16'h0fff, 12'h0, 3'h0);
    ham(1'b1, 4'h4, 1'b0, 1'b1, 16'h0, 12'h0, 3'h0);
    rchk(NPE_OFS_PR2 + 12'h008, 32'h0);
    rs(1'b1, 3'h2);
    rchk(NPE_OFS_SR1, 32'h8);
    pulse(0);
    bus(1'b0, NPE_OFS_SR1, 32'h0);
    chk(rd & 32'h8, 32'h0);
    rs(1'b1, 3'h0);
    pulse(1);
    bus(1'b0, NPE_OFS_SR1, 32'h0);
    chk(rd & 32'h8, 32'h0);
    // Redundancy words of sub-page 1
    for (int i = 0; i < NPE_RED_WORDS; i++) begin
      red_bits[10*i +: 10] = 10'(i * 97 + 13);
      @(posedge clk);
      red_in <= '{1'b1, 3'h1, 3'(i), 10'(i * 97 + 13)};
    end
    @(posedge clk);
    red_in <= '0;
    for (int j = 0; j < NPE_BYTES_PER_SUB; j++) begin
      rchk(NPE_OFS_CW0 + 12'(4 * (10 + j)), {24'h0, red_bits[8*j +: 8]});
    end
    // Correction run, done flag and interrupt
    bus(1'b1, NPE_OFS_IMASK, 32'h1);
    bus(1'b1, NPE_OFS_CTRL, 32'h0000_0214);
    bus(1'b1, NPE_OFS_CTRL, 32'h0000_0514);
    chk(32'(starts), 32'h1);
    chk({29'h0, sub_seen}, 32'h2);
    pulse(2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rchk(NPE_OFS_ISTAT, 32'h1);
    rchk(NPE_OFS_ISTAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, NPE_OFS_CTRL, 32'h0000_0314);
    repeat (2) @(posedge clk);
    chk(32'(starts), 32'h2);
    chk({29'h0, sub_seen}, 32'h3);
    pulse(2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, NPE_OFS_ICLR, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, NPE_OFS_IMASK, 32'h0);
    bus(1'b1, NPE_OFS_CTRL, 32'h0000_0014);
    pulse(2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rchk(NPE_OFS_ISTAT, 32'h1);
    bus(1'b1, NPE_OFS_CTRL, {29'h0, NPE_TYPE_S256});
    rchk(NPE_OFS_SR1, 32'h0000_3303);
    test_done();
  end
endmodule
